// [counter_defines.vh]
// Constants for the loadable eight-bit counter and its register window
`ifndef COUNTER_DEFINES_VH
`define COUNTER_DEFINES_VH

// Data path widths
`define CNT_W              8
`define SYNC_W             16
`define WB_ADR_W           8
`define WB_DAT_W           32

// Counter values
`define CNT_RESET          8'h00
`define CNT_ONE            8'h01
`define CNT_TERMINAL       8'hFF
`define STORE_RESET        8'h00

// Synchroniser reset image: clear and load idle high, so no false clear after reset
`define SYNC_RESET         16'hC000

// Field positions in the synchronised input vector
`define SY_PORT_LO         0
`define SY_CAPTURE         8
`define SY_COUNT_CLK       9
`define SY_GATE_HIGH       10
`define SY_GATE_LOW_N      11
`define SY_DRIVE_HIGH      12
`define SY_DRIVE_LOW_N     13
`define SY_ZEROING_N       14
`define SY_PRESET_N        15

// Register byte offsets
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_STORAGE        8'h08
`define REG_COUNT          8'h0C
`define REG_EVENTS         8'h10

// Control register fields
`define CTRL_CLEAR_BIT     0
`define CTRL_LOAD_BIT      1
`define CTRL_HOLD_BIT      2
`define CTRL_HOLD_RESET    1'b0

// Event register fields
`define EV_WRAP_BIT        0
`define EV_CAPTURE_BIT     1
`define EV_W               2
`define EV_RESET           2'b00

// Clock
`define CLK_PERIOD_NS      100

`endif

// [input_sync.v]
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps

`include "counter_defines.vh"

module input_sync
#(
    parameter                   WIDTH    = `SYNC_W,
    parameter [`SYNC_W-1:0]     INIT_VAL = `SYNC_RESET
)
(
    input  wire                 clk_i,
    input  wire                 rst_i,
    input  wire [WIDTH-1:0]     async_i,
    output wire [WIDTH-1:0]     sync_o
);

    reg [WIDTH-1:0]             meta_r;
    reg [WIDTH-1:0]             stable_r;

    // First stage feeds only the second stage
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r   <= INIT_VAL[WIDTH-1:0];
            stable_r <= INIT_VAL[WIDTH-1:0];
        end
        else
        begin
            meta_r   <= async_i;
            stable_r <= meta_r;
        end
    end

    assign sync_o = stable_r;

endmodule

// [loadable_binary_counter_8bit.v]
// Eight-bit counter preset from a capture register, with a shared three-state port
`timescale 1ns/1ps

`include "counter_defines.vh"

module loadable_binary_counter_8bit
(
    input  wire                     clk_i,
    input  wire                     rst_i,
    // Pins of the counter
    input  wire                     capture_clock_i,
    input  wire                     count_clock_i,
    input  wire                     count_gate_high_i,
    input  wire                     count_gate_low_n_i,
    input  wire                     drive_gate_high_i,
    input  wire                     drive_gate_low_n_i,
    input  wire                     count_zeroing_n_i,
    input  wire                     count_preset_n_i,
    input  wire [`CNT_W-1:0]        port_i,
    output wire [`CNT_W-1:0]        port_o,
    output wire [`CNT_W-1:0]        port_oe_o,
    output wire                     terminal_flag_n_o,
    // Classic Wishbone slave
    input  wire                     wb_cyc_i,
    input  wire                     wb_stb_i,
    input  wire                     wb_we_i,
    input  wire [`WB_ADR_W-1:0]     wb_adr_i,
    input  wire [3:0]               wb_sel_i,
    input  wire [`WB_DAT_W-1:0]     wb_dat_i,
    output wire [`WB_DAT_W-1:0]     wb_dat_o,
    output wire                     wb_ack_o
);

    // Pin synchronisation
    wire [`SYNC_W-1:0]              pins_raw;
    wire [`SYNC_W-1:0]              pins_s;

    assign pins_raw = {count_preset_n_i,
                       count_zeroing_n_i,
                       drive_gate_low_n_i,
                       drive_gate_high_i,
                       count_gate_low_n_i,
                       count_gate_high_i,
                       count_clock_i,
                       capture_clock_i,
                       port_i};

    input_sync
    #(
        .WIDTH    (`SYNC_W),
        .INIT_VAL (`SYNC_RESET)
    )
    u_sync
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .async_i  (pins_raw),
        .sync_o   (pins_s)
    );

    wire [`CNT_W-1:0]               port_s;
    wire                            capture_s;
    wire                            count_clk_s;
    wire                            gate_high_s;
    wire                            gate_low_n_s;
    wire                            drive_high_s;
    wire                            drive_low_n_s;
    wire                            zeroing_n_s;
    wire                            preset_n_s;

    assign port_s        = pins_s[`SY_PORT_LO +: `CNT_W];
    assign capture_s     = pins_s[`SY_CAPTURE];
    assign count_clk_s   = pins_s[`SY_COUNT_CLK];
    assign gate_high_s   = pins_s[`SY_GATE_HIGH];
    assign gate_low_n_s  = pins_s[`SY_GATE_LOW_N];
    assign drive_high_s  = pins_s[`SY_DRIVE_HIGH];
    assign drive_low_n_s = pins_s[`SY_DRIVE_LOW_N];
    assign zeroing_n_s   = pins_s[`SY_ZEROING_N];
    assign preset_n_s    = pins_s[`SY_PRESET_N];

    // Edge detection on the synchronised clock pins
    reg                             capture_prev_r;
    reg                             count_clk_prev_r;
    wire                            capture_rise;
    wire                            count_rise;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            capture_prev_r   <= 1'b0;
            count_clk_prev_r <= 1'b0;
        end
        else
        begin
            capture_prev_r   <= capture_s;
            count_clk_prev_r <= count_clk_s;
        end
    end

    // Pin clocks are sampled, so each must stay high and low for over one clk_i period
    assign capture_rise = capture_s & ~capture_prev_r;
    assign count_rise   = count_clk_s & ~count_clk_prev_r;

    // Software control
    reg                             soft_clear_r;
    reg                             soft_load_r;
    reg                             hold_r;
    reg  [`EV_W-1:0]                events_r;

    // Gate decode
    wire                            count_enable;
    wire                            drive_enable;
    wire                            do_clear;
    wire                            do_load;
    wire                            do_count;

    assign count_enable = gate_high_s & ~gate_low_n_s;
    assign drive_enable = drive_high_s & ~drive_low_n_s;
    assign do_clear     = ~zeroing_n_s | soft_clear_r;
    assign do_load      = ~preset_n_s | soft_load_r;
    assign do_count     = count_rise & count_enable & ~hold_r;

    // Storage register
    reg  [`CNT_W-1:0]               storage_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            storage_r <= `STORE_RESET;
        end
        else if (capture_rise)
        begin
            storage_r <= port_s;
        end
    end

    // Counter
    reg  [`CNT_W-1:0]               count_r;
    reg  [`CNT_W-1:0]               count_nxt;

    always @*
    begin
        count_nxt = count_r;
        if (do_clear)
        begin
            count_nxt = `CNT_RESET;
        end
        else if (do_load)
        begin
            // Load is a level, so a capture during it is still taken
            count_nxt = storage_r;
        end
        else if (do_count)
        begin
            count_nxt = count_r + `CNT_ONE;
        end
    end

    reg                             flag_n_r;
    reg  [`CNT_W-1:0]               port_out_r;
    reg                             port_en_r;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_r    <= `CNT_RESET;
            flag_n_r   <= 1'b1;
            port_out_r <= `CNT_RESET;
            port_en_r  <= 1'b0;
        end
        else
        begin
            count_r    <= count_nxt;
            flag_n_r   <= ~(count_nxt == `CNT_TERMINAL);
            port_out_r <= count_nxt;
            port_en_r  <= drive_enable;
        end
    end

    assign terminal_flag_n_o = flag_n_r;
    assign port_o            = port_out_r;
    assign port_oe_o         = {`CNT_W{port_en_r}};

    // Wishbone slave: ack one cycle after the request, dropped the next cycle
    reg                             ack_r;
    reg  [`WB_DAT_W-1:0]            dat_r;
    reg  [`WB_DAT_W-1:0]            rd_mux;
    wire                            req;
    wire                            wr_take;

    assign req     = wb_cyc_i & wb_stb_i;
    assign wr_take = req & ack_r & wb_we_i;

    always @*
    begin
        rd_mux = {`WB_DAT_W{1'b0}};
        case (wb_adr_i)
            `REG_CTRL:
            begin
                rd_mux[`CTRL_HOLD_BIT] = hold_r;
            end
            `REG_STATUS:
            begin
                rd_mux[0] = flag_n_r;
                rd_mux[1] = port_en_r;
                rd_mux[2] = count_enable;
                rd_mux[3] = do_clear;
                rd_mux[4] = do_load;
            end
            `REG_STORAGE:
            begin
                rd_mux[`CNT_W-1:0] = storage_r;
            end
            `REG_COUNT:
            begin
                rd_mux[`CNT_W-1:0] = count_r;
            end
            `REG_EVENTS:
            begin
                rd_mux[`EV_W-1:0] = events_r;
            end
            default:
            begin
                rd_mux = {`WB_DAT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= {`WB_DAT_W{1'b0}};
        end
        else
        begin
            ack_r <= req & ~ack_r;
            if (req & ~ack_r)
            begin
                dat_r <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Control writes; clear and load are one-cycle strobes
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            soft_clear_r <= 1'b0;
            soft_load_r  <= 1'b0;
            hold_r       <= `CTRL_HOLD_RESET;
        end
        else
        begin
            soft_clear_r <= 1'b0;
            soft_load_r  <= 1'b0;
            if (wr_take && wb_adr_i == `REG_CTRL && wb_sel_i[0])
            begin
                soft_clear_r <= wb_dat_i[`CTRL_CLEAR_BIT];
                soft_load_r  <= wb_dat_i[`CTRL_LOAD_BIT];
                hold_r       <= wb_dat_i[`CTRL_HOLD_BIT];
            end
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear
    wire [`EV_W-1:0]                ev_set;
    wire [`EV_W-1:0]                ev_clr;

    assign ev_set[`EV_WRAP_BIT]    = ~do_clear & ~do_load & do_count
                                     & (count_r == `CNT_TERMINAL);
    assign ev_set[`EV_CAPTURE_BIT] = capture_rise;
    assign ev_clr = (wr_take && wb_adr_i == `REG_EVENTS && wb_sel_i[0])
                    ? wb_dat_i[`EV_W-1:0] : `EV_RESET;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            events_r <= `EV_RESET;
        end
        else
        begin
            events_r <= (events_r & ~ev_clr) | ev_set;
        end
    end

endmodule

// [counter_properties.sv]
// Port checks on the loadable counter
`timescale 1ns/1ps
module counter_properties
(
    input wire        clk_i,
    input wire        rst_i,
    input wire        capture_clock_i,
    input wire        count_clock_i,
    input wire        count_gate_high_i,
    input wire        count_gate_low_n_i,
    input wire        drive_gate_high_i,
    input wire        drive_gate_low_n_i,
    input wire        count_zeroing_n_i,
    input wire        count_preset_n_i,
    input wire [7:0]  port_i,
    input wire [7:0]  port_o,
    input wire [7:0]  port_oe_o,
    input wire        terminal_flag_n_o,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Six quiet cycles flush the pin synchronisers
    sequence quiet_ctl;
        (count_zeroing_n_i && count_preset_n_i && !wb_cyc_i)[*6];
    endsequence
    sequence gate_off;
        (!count_gate_high_i || count_gate_low_n_i)[*6];
    endsequence
    flag_at_ff_a: assert property (terminal_flag_n_o == (port_o != 8'hFF))
        else $error("flag does not track all ones");
    count_step_a: assert property (quiet_ctl ##0 $changed(port_o) |-> port_o == $past(port_o) + 8'h01)
        else $error("count moved by other than one");
    gate_hold_a: assert property (gate_off and quiet_ctl |-> $stable(port_o))
        else $error("count moved with gate shut");
    clear_zero_a: assert property ((!count_zeroing_n_i)[*5] |-> port_o == 8'h00)
        else $error("clear did not zero count");
    drive_on_a: assert property ((drive_gate_high_i && !drive_gate_low_n_i)[*6] |-> port_oe_o == 8'hFF)
        else $error("port not driven");
    drive_off_a: assert property ((!drive_gate_high_i || drive_gate_low_n_i)[*6] |-> port_oe_o == 8'h00)
        else $error("port driven while gated off");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
endmodule
bind loadable_binary_counter_8bit counter_properties chk (.*);

// [system_logic_model.sv]
// System logic model driving the counter pins and sharing its port
`timescale 1ns/1ps
module system_logic_model
(
    input  wire       clk_i,
    input  wire [7:0] dev_port_i,
    input  wire [7:0] dev_oe_i,
    input  wire       flag_n_i,
    output reg        cap_o = 1'b0,
    output reg        cclk_o = 1'b0,
    output reg        gh_o = 1'b1,
    output reg        gl_n_o = 1'b0,
    output reg        dh_o = 1'b0,
    output reg        dl_n_o = 1'b1,
    output reg        zero_n_o = 1'b1,
    output reg        pre_n_o = 1'b1,
    output wire [7:0] port_o,
    output wire       chain_gate_n_o,
    output wire       chain_clk_o
);
    reg [7:0] data_r = 8'h00;
    assign port_o = (dev_oe_i & dev_port_i) | (~dev_oe_i & data_r);
    // A following stage would take the flag here
    assign chain_gate_n_o = flag_n_i;
    assign chain_clk_o = flag_n_i;
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Three cycles a phase, else the synchronisers may miss it
    task automatic pulse_count(input int n);
        repeat (n)
        begin
            cclk_o <= 1'b1;
            wait_n(3);
            cclk_o <= 1'b0;
            wait_n(3);
        end
    endtask
    task automatic capture(input logic [7:0] v);
        data_r <= v;
        wait_n(3);
        cap_o <= 1'b1;
        wait_n(3);
        cap_o <= 1'b0;
        wait_n(3);
    endtask
    task automatic preset(input logic [7:0] v);
        pre_n_o <= 1'b0;
        capture(v);
        pre_n_o <= 1'b1;
        wait_n(5);
    endtask
    task automatic clear(input logic ld);
        zero_n_o <= 1'b0;
        pre_n_o <= ~ld;
        wait_n(6);
        zero_n_o <= 1'b1;
        pre_n_o <= 1'b1;
        wait_n(5);
    endtask
    task automatic gates(input logic h, input logic l);
        gh_o <= h;
        gl_n_o <= l;
        wait_n(4);
    endtask
    task automatic drives(input logic h, input logic l);
        dh_o <= h;
        dl_n_o <= l;
        wait_n(8);
    endtask
endmodule

// [tb_loadable_binary_counter_8bit.sv]
// Self-checking bench for the loadable counter
`timescale 1ns/1ps
`include "counter_defines.vh"
module tb_loadable_binary_counter_8bit;
    reg          clk_i = 1'b0;
    reg          rst_i = 1'b1;
    reg          wb_cyc_i = 1'b0;
    reg          wb_stb_i = 1'b0;
    reg          wb_we_i = 1'b0;
    reg  [7:0]   wb_adr_i = 8'h00;
    reg  [3:0]   wb_sel_i = 4'hF;
    reg  [31:0]  wb_dat_i = 32'h0;
    wire [31:0]  wb_dat_o;
    wire         wb_ack_o, terminal_flag_n_o, capture_clock_i, count_clock_i;
    wire         count_gate_high_i, count_gate_low_n_i, drive_gate_high_i;
    wire         drive_gate_low_n_i, count_zeroing_n_i, count_preset_n_i;
    wire [7:0]   port_i, port_o, port_oe_o;
    int          fails = 0;
    int          comparisons = 0;
    logic [32:0] notes[$];
    logic [32:0] nt;
    logic [7:0]  v, c;
    int          n;
    loadable_binary_counter_8bit uut (.*);
    system_logic_model sys (.clk_i(clk_i), .dev_port_i(port_o), .dev_oe_i(port_oe_o),
        .flag_n_i(terminal_flag_n_o), .cap_o(capture_clock_i), .cclk_o(count_clock_i),
        .gh_o(count_gate_high_i), .gl_n_o(count_gate_low_n_i), .dh_o(drive_gate_high_i),
        .dl_n_o(drive_gate_low_n_i), .zero_n_o(count_zeroing_n_i),
        .pre_n_o(count_preset_n_i), .port_o(port_i), .chain_gate_n_o(), .chain_clk_o());
    initial forever #50 clk_i = ~clk_i;
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Reads note the expected word; writes note nothing to compare
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        notes.push_back({~w, d});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'($urandom) | {3'h0, w};
        wb_dat_i <= w ? d : $urandom;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && notes.size() > 0)
        begin
            nt = notes.pop_front();
            if (nt[32])
                cmp("wb_dat_o", nt[31:0], wb_dat_o);
        end
    task automatic give_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        fails++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(66));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        sys.wait_n(4);
        wb(`REG_COUNT, 1'b0, 32'h0);
        wb(`REG_STATUS, 1'b0, 32'h5);
        v = 8'($urandom_range(224, 16));
        sys.preset(v);
        wb(`REG_STORAGE, 1'b0, {24'h0, v});
        wb(`REG_COUNT, 1'b0, {24'h0, v});
        sys.capture(~v);
        sys.preset(v);
        sys.clear(1'b0);
        sys.preset(v);
        c = v;
        for (int i = 0; i < 4; i++)
        begin
            sys.gates(i[1], i[0]);
            sys.pulse_count(1);
            c = c + (i == 2);
            wb(`REG_COUNT, 1'b0, {24'h0, c});
        end
        sys.gates(1'b1, 1'b0);
        n = $urandom_range(4, 1);
        sys.pulse_count(n);
        c = c + 8'(n);
        wb(`REG_COUNT, 1'b0, {24'h0, c});
        for (int i = 0; i < 4; i++)
        begin
            sys.drives(i[1], i[0]);
            cmp("port_oe_o", (i == 2) ? 8'hFF : 8'h00, port_oe_o);
            cmp("port_i", (i == 2) ? c : v, port_i);
        end
        sys.preset(8'hFE);
        sys.pulse_count(1);
        cmp("terminal_flag_n_o", 1'b0, terminal_flag_n_o);
        sys.pulse_count(1);
        wb(`REG_COUNT, 1'b0, 32'h0);
        cmp("terminal_flag_n_o", 1'b1, terminal_flag_n_o);
        wb(`REG_EVENTS, 1'b0, 32'h3);
        wb(`REG_EVENTS, 1'b1, 32'h3);
        wb(`REG_EVENTS, 1'b0, 32'h0);
        sys.preset(8'h5A);
        sys.clear(1'b1);
        wb(`REG_COUNT, 1'b0, 32'h0);
        wb(`REG_CTRL, 1'b1, 32'h4);
        wb(`REG_CTRL, 1'b0, 32'h4);
        sys.pulse_count(2);
        wb(`REG_COUNT, 1'b0, 32'h0);
        wb(`REG_CTRL, 1'b1, 32'h0);
        sys.pulse_count(3);
        wb(`REG_COUNT, 1'b0, 32'h3);
        wb(`REG_CTRL, 1'b1, 32'h1);
        sys.wait_n(6);
        wb(`REG_COUNT, 1'b0, 32'h0);
        wb(`REG_CTRL, 1'b1, 32'h2);
        sys.wait_n(2);
        wb(`REG_COUNT, 1'b0, 32'h5A);
        wb(8'h20, 1'b1, 32'hFFFFFFFF);
        wb(8'h20, 1'b0, 32'h0);
        sys.wait_n(4);
        give_verdict();
    end
endmodule
